// ### logic/tuner_control_status_bank.sv
/*
  control and status bank of the tuner: decodes control fields, runs the band word calibration and
  serves the two-byte read frame on the two-wire serial bus (device address, then two status bytes).
  assumes control fields arrive already written, comparators, lock, supply monitor and level come from
  the analog side, scl/sda arrive asynchronously, and cmp_tick pulses once per comparison period.
*/
`timescale 1ns/1ns
module tuner_control_status_bank #(
  parameter logic [6:0] DEV_ADDR   = tuner_pkg::DEV_ADDR_DEFAULT,
  parameter int         WAIT_SHORT = tuner_pkg::CAL_WAIT_SHORT,
  parameter int         WAIT_LONG  = tuner_pkg::CAL_WAIT_LONG
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire tuner_pkg::ctrl_t       ctrl,
  input  wire logic                   band_written,
  input  wire logic                   cmp_tick,
  input  wire logic                   supply_low,
  input  wire logic                   pll_locked,
  input  wire logic                   tuning_above_upper,
  input  wire logic                   tuning_below_lower,
  input  wire logic [1:0]             input_level,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic                        open_drain_out_a_oe,
  output logic                        open_drain_out_b_oe,
  output tuner_pkg::analog_ctl_t      analog_ctl,
  output logic [1:0]                  upper_threshold,
  output logic [1:0]                  lower_threshold,
  output logic [4:0]                  band_word_readback,
  output logic                        cal_busy
);
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_ADDR = 4'h2,
    BUS_SEND = 4'h4,
    BUS_ACKW = 4'h8
  } bus_state_t;

  typedef enum logic [2:0] {
    CAL_IDLE = 3'h1,
    CAL_WAIT = 3'h2,
    CAL_STEP = 3'h4
  } cal_state_t;

  function automatic logic [16:0] wait_count(input logic sel);
    wait_count = sel ? 17'(WAIT_LONG) : 17'(WAIT_SHORT);
  endfunction : wait_count

  // two-flop synchronisers for the bus pins and the supply, lock and comparator levels; input_level is used unsynchronised
  logic [1:0] scl_sync, sda_sync, sup_sync, lock_sync, up_sync, dn_sync;
  logic       scl_q, sda_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      sup_sync  <= 2'h0;
      lock_sync <= 2'h0;
      up_sync   <= 2'h0;
      dn_sync   <= 2'h0;
      scl_q     <= 1'h1;
      sda_q     <= 1'h1;
    end else begin
      scl_sync  <= {scl_sync[0], scl_in};
      sda_sync  <= {sda_sync[0], sda_in};
      sup_sync  <= {sup_sync[0], supply_low};
      lock_sync <= {lock_sync[0], pll_locked};
      up_sync   <= {up_sync[0], tuning_above_upper};
      dn_sync   <= {dn_sync[0], tuning_below_lower};
      scl_q     <= scl_sync[1];
      sda_q     <= sda_sync[1];
    end
  end

  wire scl_rise = scl_sync[1] & ~scl_q;
  wire scl_fall = ~scl_sync[1] & scl_q;
  wire start_c  = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire stop_c   = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

  // plain decodes of the control fields
  always_comb begin
    analog_ctl.lna_atten         = ctrl.rf_atten_sel;
    analog_ctl.pump_high_current = ctrl.pump_current_sel;
    analog_ctl.main_sink_on      = ctrl.main_pump_test_en & ctrl.pump_up_force;
    analog_ctl.main_source_on    = ctrl.main_pump_test_en & ctrl.pump_down_force;
    analog_ctl.second_sink_on    = ctrl.second_pump_test_en & ~ctrl.second_pump_force;
    analog_ctl.second_source_on  = ctrl.second_pump_test_en & ctrl.second_pump_force;
    analog_ctl.second_bank_on    = ctrl.pump_bank_sel;
    open_drain_out_a_oe          = ctrl.open_drain_out_a;
    open_drain_out_b_oe          = ctrl.open_drain_out_b;
    upper_threshold              = ctrl.upper_thresh_sel;
    lower_threshold              = ctrl.lower_thresh_sel;
  end

  // calibration: count comparison ticks, then step toward the asserted comparator
  cal_state_t  cal_state, next_cal_state;
  logic [16:0] wait_cnt, next_wait_cnt;
  logic [4:0]  band_cal, next_band_cal;
  logic        cal_err, next_cal_err;

  always_comb begin
    next_cal_state = cal_state;
    next_wait_cnt  = wait_cnt;
    next_band_cal  = band_cal;
    next_cal_err   = cal_err;
    case (cal_state)
      CAL_IDLE: begin
      end
      CAL_WAIT: begin
        if (cmp_tick) begin
          if (wait_cnt <= 17'h00001) begin
            next_cal_state = CAL_STEP;
          end else begin
            next_wait_cnt = wait_cnt - 17'h00001;
          end
        end
      end
      CAL_STEP: begin
        next_wait_cnt  = wait_count(ctrl.cal_wait_sel);
        next_cal_state = CAL_WAIT;
        if (up_sync[1]) begin
          if (band_cal == tuner_pkg::BAND_MAX) begin
            next_cal_err   = 1'h1;
            next_cal_state = CAL_IDLE;
          end else begin
            next_band_cal = band_cal + 5'h01;
          end
        end else if (dn_sync[1]) begin
          if (band_cal == tuner_pkg::BAND_MIN) begin
            next_cal_err   = 1'h1;
            next_cal_state = CAL_IDLE;
          end else begin
            next_band_cal = band_cal - 5'h01;
          end
        end else begin
          next_cal_state = CAL_IDLE;
        end
      end
      default: next_cal_state = CAL_IDLE;
    endcase
    // a new band word restarts the search in automatic mode; manual mode never searches
    if (band_written) begin
      next_band_cal = ctrl.band_word;
      // a limit hit in this very cycle still shows: the set wins over the restart's clear
      next_cal_err  = next_cal_err & (cal_state == CAL_STEP);
      next_wait_cnt = wait_count(ctrl.cal_wait_sel);
      next_cal_state = ctrl.cal_mode_sel ? CAL_IDLE : CAL_WAIT;
    end
    if (ctrl.cal_mode_sel) begin
      next_cal_state = CAL_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cal_state <= CAL_IDLE;
      wait_cnt  <= 17'h00000;
      band_cal  <= 5'h00;
      cal_err   <= 1'h0;
    end else begin
      cal_state <= next_cal_state;
      wait_cnt  <= next_wait_cnt;
      band_cal  <= next_band_cal;
      cal_err   <= next_cal_err;
    end
  end

  assign band_word_readback = ctrl.cal_mode_sel ? ctrl.band_word : band_cal;
  assign cal_busy           = (cal_state != CAL_IDLE);

  // serial read slave
  bus_state_t bus_state, next_bus_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic       byte_idx, next_byte_idx;
  logic       drv, next_drv;
  logic       ack_phase, next_ack_phase;
  logic       poweron, next_poweron;
  logic       read_done, next_read_done;
  logic [7:0] status_byte0, status_byte1;

  always_comb begin
    status_byte0 = 8'h00;
    status_byte0[tuner_pkg::FLAG_POS_POWERON] = poweron;
    status_byte0[tuner_pkg::FLAG_POS_LOCK]    = lock_sync[1];
    status_byte0[tuner_pkg::FLAG_POS_UPPER]   = up_sync[1];
    status_byte0[tuner_pkg::FLAG_POS_LOWER]   = dn_sync[1];
    status_byte0[tuner_pkg::FLAG_POS_CALERR]  = cal_err;
    status_byte1 = {tuner_pkg::BYTE1_CONST, input_level, band_word_readback};
  end

  always_comb begin
    next_bus_state = bus_state;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_byte_idx  = byte_idx;
    next_drv       = drv;
    next_ack_phase = ack_phase;
    next_read_done = read_done;
    next_poweron   = poweron;
    case (bus_state)
      BUS_IDLE: begin
        next_drv = 1'h0;
      end
      BUS_ADDR: begin
        if (scl_rise && !ack_phase) begin
          next_shreg   = {shreg[6:0], sda_sync[1]};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        if (scl_fall) begin
          if (ack_phase) begin
            next_ack_phase = 1'h0;
            next_bus_state = BUS_SEND;
            next_shreg     = status_byte0;
            next_byte_idx  = 1'h0;
            next_bit_cnt   = 4'h0;
            next_drv       = ~status_byte0[7];
          end else if (bit_cnt == 4'h8) begin
            // only a read to our address is answered; writes belong to another block
            if (shreg == {DEV_ADDR, 1'h1}) begin
              next_ack_phase = 1'h1;
              next_drv       = 1'h1;
            end else begin
              next_bus_state = BUS_IDLE;
            end
          end
        end
      end
      BUS_SEND: begin
        if (scl_fall) begin
          if (bit_cnt == 4'h7) begin
            next_drv       = 1'h0;
            next_bus_state = BUS_ACKW;
          end else begin
            next_shreg   = {shreg[6:0], 1'h0};
            next_bit_cnt = bit_cnt + 4'h1;
            next_drv     = ~shreg[6];
          end
        end
      end
      BUS_ACKW: begin
        if (scl_rise) begin
          if (byte_idx) begin
            next_read_done = 1'h1;
          end
          next_ack_phase = ~sda_sync[1] & ~byte_idx;
        end
        if (scl_fall) begin
          if (ack_phase) begin
            next_ack_phase = 1'h0;
            next_byte_idx  = 1'h1;
            next_bit_cnt   = 4'h0;
            next_shreg     = status_byte1;
            next_drv       = ~status_byte1[7];
            next_bus_state = BUS_SEND;
          end else begin
            next_bus_state = BUS_IDLE;
          end
        end
      end
      default: next_bus_state = BUS_IDLE;
    endcase
    if (start_c) begin
      next_bus_state = BUS_ADDR;
      next_bit_cnt   = 4'h0;
      next_ack_phase = 1'h0;
      next_drv       = 1'h0;
      next_read_done = 1'h0;
    end
    if (stop_c) begin
      next_bus_state = BUS_IDLE;
      next_drv       = 1'h0;
      next_read_done = 1'h0;
      if (read_done) begin
        next_poweron = 1'h0;
      end
    end
    // a supply drop wins over a clear in the same cycle
    if (sup_sync[1]) begin
      next_poweron = 1'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      byte_idx  <= 1'h0;
      drv       <= 1'h0;
      ack_phase <= 1'h0;
      poweron   <= 1'h1;
      read_done <= 1'h0;
    end else begin
      bus_state <= next_bus_state;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      byte_idx  <= next_byte_idx;
      drv       <= next_drv;
      ack_phase <= next_ack_phase;
      poweron   <= next_poweron;
      read_done <= next_read_done;
    end
  end

  // open-drain: only ever pull low
  assign sda_out = 1'h0;
  assign sda_oe  = drv;
endmodule : tuner_control_status_bank

// ### logic/tuner_pkg.sv
/*
  package for the tuner control and status bank: read frame layout, calibration counts, carrier types.
  assumes a 25 MHz system clock and a comparison-frequency tick from the synthesizer.
*/
package tuner_pkg;
  localparam logic [6:0]  DEV_ADDR_DEFAULT  = 7'h60;  // arbitrary value
  localparam logic [3:0]  STATUS_FLAGS_OFS  = 4'h0;
  localparam logic [3:0]  LEVEL_BAND_OFS    = 4'h1;
  localparam logic        BYTE1_CONST       = 1'h1;
  localparam int          FLAG_POS_POWERON  = 7;
  localparam int          FLAG_POS_LOCK     = 6;
  localparam int          FLAG_POS_UPPER    = 5;
  localparam int          FLAG_POS_LOWER    = 4;
  localparam int          FLAG_POS_CALERR   = 3;
  localparam int          CAL_WAIT_SHORT    = 28673;
  localparam int          CAL_WAIT_LONG     = 32769;
  localparam logic [4:0]  BAND_MIN          = 5'h00;
  localparam logic [4:0]  BAND_MAX          = 5'h1F;
  localparam logic [2:0]  OSC_AMP_ALLOWED   = 3'h4;
  localparam logic [3:0]  BB_BIAS_ALLOWED   = 4'hD;
  localparam logic [1:0]  UPPER_THRESH_REC  = 2'h3;
  localparam logic [1:0]  LOWER_THRESH_REC  = 2'h1;

  typedef struct packed {
    logic       rf_atten_sel;
    logic       pump_current_sel;
    logic       main_pump_test_en;
    logic       pump_up_force;
    logic       pump_down_force;
    logic       second_pump_test_en;
    logic       second_pump_force;
    logic       pump_bank_sel;
    logic [2:0] osc_amplitude;
    logic       open_drain_out_b;
    logic       open_drain_out_a;
    logic       cal_wait_sel;
    logic [1:0] upper_thresh_sel;
    logic [1:0] lower_thresh_sel;
    logic [3:0] baseband_bias;
    logic       cal_mode_sel;
    logic [4:0] band_word;
  } ctrl_t;

  typedef struct packed {
    logic lna_atten;
    logic pump_high_current;
    logic main_sink_on;
    logic main_source_on;
    logic second_sink_on;
    logic second_source_on;
    logic second_bank_on;
  } analog_ctl_t;
endpackage : tuner_pkg

// ### testbench/tuner_control_status_bank_asserts.sv
/* port checker for the tuner bank: decode, manual readback, calibration start, bus edges.
   assumes it is bound into tuner_control_status_bank and sees only its ports. */
`timescale 1ns/1ns
module tuner_bank_checker (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire tuner_pkg::ctrl_t       ctrl,
  input wire logic                   band_written,
  input wire logic                   scl_in,
  input wire logic                   sda_oe,
  input wire logic                   open_drain_out_a_oe,
  input wire logic                   open_drain_out_b_oe,
  input wire tuner_pkg::analog_ctl_t analog_ctl,
  input wire logic [1:0]             upper_threshold,
  input wire logic [1:0]             lower_threshold,
  input wire logic [4:0]             band_word_readback,
  input wire logic                   cal_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  atten_decode_a:
    assert property (analog_ctl.lna_atten == ctrl.rf_atten_sel) else $error("lna attenuation wrong");
  pump_current_a:
    assert property (analog_ctl.pump_high_current == ctrl.pump_current_sel) else $error("pump current wrong");
  main_test_a:
    assert property ({analog_ctl.main_sink_on, analog_ctl.main_source_on} ==
      ({2{ctrl.main_pump_test_en}} & {ctrl.pump_up_force, ctrl.pump_down_force})) else $error("main test wrong");
  second_test_a:
    assert property ({analog_ctl.second_sink_on, analog_ctl.second_source_on} ==
      ({2{ctrl.second_pump_test_en}} & {~ctrl.second_pump_force, ctrl.second_pump_force})) else $error("test2 wrong");
  pump_bank_a:
    assert property (analog_ctl.second_bank_on == ctrl.pump_bank_sel) else $error("pump bank wrong");
  port_sink_a:
    assert property ({open_drain_out_b_oe, open_drain_out_a_oe} == {ctrl.open_drain_out_b, ctrl.open_drain_out_a})
      else $error("port sink wrong");
  thresh_copy_a:
    assert property ({upper_threshold, lower_threshold} == {ctrl.upper_thresh_sel, ctrl.lower_thresh_sel})
      else $error("threshold copy wrong");
  manual_band_a:
    assert property (ctrl.cal_mode_sel |-> band_word_readback == ctrl.band_word) else $error("manual band wrong");
  cal_start_a:
    assert property (band_written && !ctrl.cal_mode_sel |-> ##[1:2] cal_busy) else $error("calibration not started");
  cal_cause_a:
    assert property ($rose(cal_busy) |-> $past(band_written) || $past(band_written, 2)) else $error("busy uncaused");
  sda_edge_a:
    assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  cover property ($rose(sda_oe));
  cover property ($fell(cal_busy));
  cover property (analog_ctl.main_sink_on && analog_ctl.main_source_on);
endmodule : tuner_bank_checker
bind tuner_control_status_bank tuner_bank_checker checker_inst (.clk_sys, .rst, .ctrl, .band_written, .scl_in,
  .sda_oe, .open_drain_out_a_oe, .open_drain_out_b_oe, .analog_ctl, .upper_threshold, .lower_threshold,
  .band_word_readback, .cal_busy);

// ### testbench/bus_master_model.sv
/* serial bus master model: start, address and direction, ack, two status bytes, stop.
   assumes the bench resolves the open-drain data line with a pull-up; qn sets a quarter bit. */
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic       clk_sys,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_low,
  output logic [7:0]      rx_byte,
  output logic            rx_valid
);
  int qn = 2;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end
  task automatic q();
    repeat (qn) @(negedge clk_sys);
  endtask : q
  // data only moves while the clock is low, so no false start or stop
  task automatic bit_io(input logic d, output logic s);
    q();
    sda_low <= ~d;
    q();
    scl <= 1'b1;
    q();
    s = sda_line;
    q();
    scl <= 1'b0;
  endtask : bit_io
  task automatic get_byte(input logic ack_it);
    logic [7:0] b;
    logic       s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    rx_byte <= b;
    rx_valid <= 1'b1;
    @(negedge clk_sys);
    rx_valid <= 1'b0;
    bit_io(~ack_it, s);
  endtask : get_byte
  task automatic read_frame(input logic [6:0] addr, input logic rd, output logic ack);
    logic s;
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    for (int i = 6; i >= 0; i--) bit_io(addr[i], s);
    bit_io(rd, s);
    bit_io(1'b1, s);
    ack = ~s;
    if (ack) begin
      get_byte(1'b1);
      get_byte(1'b0);
    end
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask : read_frame
endmodule : bus_master_model

// ### testbench/tuner_control_status_bank_tb.sv
/* self-checking bench for the tuner bank: decode, calibration waits, read frame and flags.
   assumes short calibration waits and a bus master model on an open-drain line with pull-up. */
`timescale 1ns/1ns
module tuner_control_status_bank_tb;
  localparam int WS = 4;
  localparam int WL = 6;
  tuner_pkg::ctrl_t       ctrl;
  tuner_pkg::analog_ctl_t actl;
  logic                   clk_sys, rst, band_written, cmp_tick, supply_low, pll_locked;
  logic                   tuning_above_upper, tuning_below_lower, scl, sda_low, sda_line, sda_out, sda_oe;
  logic                   oe_a, oe_b, cal_busy, rx_valid, por, err;
  logic [1:0]             input_level, upper_threshold, lower_threshold;
  logic [4:0]             band_word_readback, band;
  logic [7:0]             rx_byte;
  logic [15:0]            expq[$];
  int                     errors, n_checks;
  assign sda_line = ~sda_low & (sda_oe ? sda_out : 1'b1);
  tuner_control_status_bank #(.WAIT_SHORT(WS), .WAIT_LONG(WL)) tuner_control_status_bank_inst (
    .clk_sys, .rst, .ctrl, .band_written, .cmp_tick, .supply_low, .pll_locked, .tuning_above_upper,
    .tuning_below_lower, .input_level, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe,
    .open_drain_out_a_oe(oe_a), .open_drain_out_b_oe(oe_b), .analog_ctl(actl), .upper_threshold,
    .lower_threshold, .band_word_readback, .cal_busy);
  bus_master_model bus_master_model_inst (.clk_sys, .sda_line, .scl, .sda_low, .rx_byte, .rx_valid);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : w
  task automatic tk(input int n);
    repeat (n) begin
      cmp_tick = 1'b1;
      w(1);
      cmp_tick = 1'b0;
      w(1);
    end
  endtask : tk
  task automatic bw();
    band_written = 1'b1;
    w(1);
    band_written = 1'b0;
    err = 1'b0;
  endtask : bw
  task automatic rd(input logic [6:0] a, input logic dir);
    logic ack;
    // undefined low bits of the flag byte are masked off
    if (a == tuner_pkg::DEV_ADDR_DEFAULT && dir) begin
      expq.push_back({8'hF8, por, pll_locked, tuning_above_upper, tuning_below_lower, err, 3'h0});
      expq.push_back({8'hFF, 1'b1, input_level, band});
    end
    bus_master_model_inst.read_frame(a, dir, ack);
    chk("ack", {7'h0, a == tuner_pkg::DEV_ADDR_DEFAULT && dir}, {7'h0, ack});
    if (ack) por = 1'b0;
  endtask : rd
  always @(posedge clk_sys) begin
    if (rx_valid && expq.size() == 0) begin
      errors++;
      $display("Error read byte expected none seen %h", rx_byte);
    end else if (rx_valid) begin
      chk("read byte", expq[0][7:0], rx_byte & expq[0][15:8]);
      void'(expq.pop_front());
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    logic [31:0] r;
    logic [6:0]  e;
    void'($urandom(32'hD898903A));
    {rst, band_written, cmp_tick, supply_low, pll_locked, tuning_above_upper, tuning_below_lower} = 7'h41;
    {input_level, por, err, band, errors, n_checks} = '0;
    ctrl = '0;
    ctrl.cal_mode_sel = 1'b1;
    ctrl.osc_amplitude = tuner_pkg::OSC_AMP_ALLOWED;
    ctrl.baseband_bias = tuner_pkg::BB_BIAS_ALLOWED;
    w(3);
    rst = 1'b0;
    por = 1'b1;
    w(4);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      ctrl = r[$bits(ctrl)-1:0];
      ctrl.cal_mode_sel = 1'b1;
      // the host keeps the two fixed-value fields at their only allowed codes
      ctrl.osc_amplitude = tuner_pkg::OSC_AMP_ALLOWED;
      ctrl.baseband_bias = tuner_pkg::BB_BIAS_ALLOWED;
      w(1);
      e = {ctrl.rf_atten_sel, ctrl.pump_current_sel, ctrl.main_pump_test_en & ctrl.pump_up_force,
           ctrl.main_pump_test_en & ctrl.pump_down_force, ctrl.second_pump_test_en & ~ctrl.second_pump_force,
           ctrl.second_pump_test_en & ctrl.second_pump_force, ctrl.pump_bank_sel};
      chk("analog", {1'b0, e}, {1'b0, actl});
      chk("ports", {ctrl.open_drain_out_b, ctrl.open_drain_out_a}, {oe_b, oe_a});
      chk("thresh", {ctrl.upper_thresh_sel, ctrl.lower_thresh_sel}, {upper_threshold, lower_threshold});
      chk("band", ctrl.band_word, band_word_readback);
    end
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      {pll_locked, tuning_above_upper, tuning_below_lower, input_level} = r[4:0];
      band = ctrl.band_word;
      bus_master_model_inst.qn = 2 + 2 * (k % 2);
      w(6);
      if (k == 1) rd(tuner_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b1);
      if (k == 1) rd(tuner_pkg::DEV_ADDR_DEFAULT, 1'b0);
      if (k == 2) supply_low = 1'b1;
      w(6);
      supply_low = 1'b0;
      por = por | (k == 2);
      rd(tuner_pkg::DEV_ADDR_DEFAULT, 1'b1);
    end
    {tuning_above_upper, tuning_below_lower, ctrl.band_word, ctrl.cal_mode_sel} = '0;
    for (int s = 0; s < 2; s++) begin
      ctrl.cal_wait_sel = s[0];
      w(6);
      bw();
      tk((s ? WL : WS) - 1);
      chk("busy", 8'h01, cal_busy);
      tk(1);
      w(4);
      chk("idle", 8'h00, cal_busy);
    end
    ctrl.cal_wait_sel = 1'b0;
    // run off the bottom, then off the top, of the band range
    for (int m = 0; m < 2; m++) begin
      {tuning_above_upper, tuning_below_lower} = m ? 2'b10 : 2'b01;
      ctrl.band_word = m ? tuner_pkg::BAND_MAX : tuner_pkg::BAND_MIN;
      w(6);
      bw();
      tk(WS + 1);
      w(4);
      err = 1'b1;
      band = ctrl.band_word;
      rd(tuner_pkg::DEV_ADDR_DEFAULT, 1'b1);
    end
    ctrl.band_word = tuner_pkg::BAND_MIN;
    w(6);
    bw();
    tk(WS);
    w(3);
    tuning_above_upper = 1'b0;
    w(4);
    tk(WL);
    w(4);
    band = 5'h01;
    chk("step", band, band_word_readback);
    rd(tuner_pkg::DEV_ADDR_DEFAULT, 1'b1);
    w(10);
    chk("pending reads", 8'h00, 8'(expq.size()));
    conclude();
  end
endmodule : tuner_control_status_bank_tb
